// ---- hw/epc_top.sv ----
// eprom program-control block behind an axi4-lite slave
// assumes one clock; the array itself sits outside on plain ports
// How it works
// - latch bit clear routes array for reads
// - latch set: array write captures address, data
// - latch set: array reads return no contents
// - program bit switches programming power on/off
// - program bit forced zero without latch bit
// - both bits in one register, index 001E, bus byte address 0078
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_top #(
  parameter int ADDR_W = 12,
  parameter int ARR_AW = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // eprom array side
  output logic [ARR_AW-1:0] arr_read_addr,
  input wire logic [7:0] arr_read_data,
  output logic [ARR_AW-1:0] arr_prog_addr,
  output logic [7:0] arr_prog_data,
  output logic array_latch_mode,
  output logic program_power_on
);

  epc_pkg::epc_bus_state_t wst_q, wst_d, rst_q, rst_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [ARR_AW-1:0] paddr_q, paddr_d;
  logic [7:0] pdata_q, pdata_d;
  logic ctrl_wr;
  logic do_write;

  // register select codes out of the shared decoder
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CTRL = 3'h1;
  localparam logic [2:0] SEL_ARRAY = 3'h2;
  localparam logic [2:0] SEL_PADDR = 3'h3;
  localparam logic [2:0] SEL_PDATA = 3'h4;

  // word-aligned decode, shared by read and write paths
  function automatic logic [2:0] dec(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    // low two bits ignored: each register is one whole word
    dec = SEL_NONE;
    if (w == `EPC_CTRL_BYTE_ADDR) dec = SEL_CTRL;
    else if (w == `EPC_ARRAY_ADDR) dec = SEL_ARRAY;
    else if (w == `EPC_PROG_ADDR_ADDR) dec = SEL_PADDR;
    else if (w == `EPC_PROG_DATA_ADDR) dec = SEL_PDATA;
  endfunction

  epc_ctrl_reg u_ctrl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(ctrl_wr),
    .wr_data(wdata_q[7:0]),
    .array_latch_mode(array_latch_mode),
    .program_power_on(program_power_on)
  );

  // both halves must be in before anything moves
  assign do_write = (wst_q == epc_pkg::EPC_IDLE) && aw_have_q && w_have_q;
  assign ctrl_wr = do_write && (dec(awaddr_q) == SEL_CTRL) && wstrb_q[0];

  always_comb begin
    wst_d = wst_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    paddr_d = paddr_q;
    pdata_d = pdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    unique case (wst_q)
      epc_pkg::EPC_IDLE: begin
        if (aw_have_q && w_have_q) begin
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          wst_d = epc_pkg::EPC_WRESP;
          bresp_d = `EPC_RESP_OKAY;
          // unmapped words answer an error and change nothing
          unique case (dec(awaddr_q))
            SEL_CTRL: ;
            SEL_ARRAY: begin
              // array writes only land while latching
              if (array_latch_mode && wstrb_q[0]) begin
                paddr_d = awaddr_q[ARR_AW-1:0];
                pdata_d = wdata_q[7:0];
              end
            end
            SEL_PADDR, SEL_PDATA: ;
            default: bresp_d = `EPC_RESP_SLVERR;
          endcase
        end
      end
      epc_pkg::EPC_WRESP: begin
        // response stands until taken; no new write meanwhile
        if (s_axi_bready) wst_d = epc_pkg::EPC_IDLE;
      end
      default: wst_d = epc_pkg::EPC_IDLE;
    endcase
  end

  always_comb begin
    rst_d = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rst_q)
      epc_pkg::EPC_IDLE: begin
        if (s_axi_arvalid) begin
          // array data taken in the address cycle: no wait state
          rst_d = epc_pkg::EPC_RDATA;
          rresp_d = `EPC_RESP_OKAY;
          rdata_d = 32'h0000_0000;
          unique case (dec(s_axi_araddr))
            SEL_CTRL: rdata_d = {30'h0, array_latch_mode,
                                 program_power_on};
            // programming mode hides stored contents
            SEL_ARRAY: rdata_d = array_latch_mode ? 32'h0000_0000
                                 : {24'h00_0000, arr_read_data};
            SEL_PADDR: rdata_d = {{(32-ARR_AW){1'b0}}, paddr_q};
            SEL_PDATA: rdata_d = {24'h00_0000, pdata_q};
            default: rresp_d = `EPC_RESP_SLVERR;
          endcase
        end
      end
      epc_pkg::EPC_RDATA: begin
        if (s_axi_rready) rst_d = epc_pkg::EPC_IDLE;
      end
      default: rst_d = epc_pkg::EPC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    // sync reset: both channels idle, latches cleared
    if (!aresetn) begin
      wst_q <= epc_pkg::EPC_IDLE;
      rst_q <= epc_pkg::EPC_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      paddr_q <= '0;
      pdata_q <= 8'h00;
    end else begin
      wst_q <= wst_d;
      rst_q <= rst_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      paddr_q <= paddr_d;
      pdata_q <= pdata_d;
    end
  end

  // one write at a time: hold each channel until the response is gone
  assign s_axi_awready = !aw_have_q && (wst_q == epc_pkg::EPC_IDLE);
  assign s_axi_wready = !w_have_q && (wst_q == epc_pkg::EPC_IDLE);
  assign s_axi_bvalid = (wst_q == epc_pkg::EPC_WRESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = (rst_q == epc_pkg::EPC_IDLE);
  assign s_axi_rvalid = (rst_q == epc_pkg::EPC_RDATA);
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  // read address is live so the array can answer in the same cycle
  assign arr_read_addr = s_axi_araddr[ARR_AW-1:0];
  // programming target held steady for the whole pulse
  assign arr_prog_addr = paddr_q;
  assign arr_prog_data = pdata_q;
endmodule

// ---- hw/epc_params.svh ----
// constants for the eprom program-control block
// assumes a 32-bit axi4-lite register bus and a 50 MHz clock
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
// register index; the bus byte address is four times it
`define EPC_CTRL_ADDR 12'h001E
`define EPC_CTRL_BYTE_ADDR (`EPC_CTRL_ADDR << 2)
`define EPC_ARRAY_ADDR 12'h0080
`define EPC_PROG_ADDR_ADDR 12'h0084
`define EPC_PROG_DATA_ADDR 12'h0088
`define EPC_PGM_BIT 0
`define EPC_LAT_BIT 1
`define EPC_CTRL_RESET 8'h00
`define EPC_LAT_RESET 1'b0
`define EPC_PGM_RESET 1'b0
`define EPC_RESP_OKAY 2'h0
`define EPC_RESP_SLVERR 2'h2
`define EPC_PULSE_TIME_US 1000
`define EPC_CLK_MHZ 50
`endif

// ---- hw/epc_pkg.sv ----
// types for the eprom program-control block
// assumes epc_params.svh is included by the users
package epc_pkg;
  typedef enum logic [2:0] {
    EPC_IDLE = 3'b001,
    EPC_WRESP = 3'b010,
    EPC_RDATA = 3'b100
  } epc_bus_state_t;
endpackage

// ---- hw/epc_ctrl_reg.sv ----
// control register: latch-mode and program-power bits
// assumes a write strobe from the bus slave on the same clock
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_ctrl_reg (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // state
  output logic array_latch_mode,
  output logic program_power_on
);
  logic lat_q;
  logic lat_d;
  logic pgm_q;
  logic pgm_d;

  always_comb begin
    lat_d = lat_q;
    pgm_d = pgm_q;
    if (wr_en) begin
      lat_d = wr_data[`EPC_LAT_BIT];
      // power only ever follows a latch bit that is set
      pgm_d = wr_data[`EPC_PGM_BIT] & wr_data[`EPC_LAT_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_q <= `EPC_LAT_RESET;
      pgm_q <= `EPC_PGM_RESET;
    end else begin
      lat_q <= lat_d;
      pgm_q <= pgm_d;
    end
  end

  assign array_latch_mode = lat_q;
  assign program_power_on = pgm_q & lat_q;
endmodule

// ---- sim/epc_assertions.sv ----
// checker for the eprom program-control block
// assumes a bind onto epc_top, one clock, sync active-low reset
`timescale 1ns/100ps
`include "epc_params.svh"
module epc_assertions #(
  parameter int ADDR_W = 12,
  parameter int ARR_AW = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  // array side
  input wire logic [ARR_AW-1:0] arr_read_addr,
  input wire logic [7:0] arr_read_data,
  input wire logic [ARR_AW-1:0] arr_prog_addr,
  input wire logic array_latch_mode,
  input wire logic program_power_on
);
  logic live_q;
  // one quiet edge after reset keeps $past clear of pre-reset values
  always_ff @(posedge aclk) begin
    live_q <= aresetn;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !live_q);
  sequence arr_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `EPC_ARRAY_ADDR;
  endsequence
  chk_power_gated: assert property (program_power_on |-> array_latch_mode)
    else $error("power on outside latch mode");
  chk_locked_read: assert property (arr_rd ##0 array_latch_mode
    |=> s_axi_rdata == 32'h0000_0000) else $error("locked array read");
  chk_plain_read: assert property (arr_rd ##0 !array_latch_mode
    |=> s_axi_rdata == {24'h00_0000, $past(arr_read_data)})
    else $error("array read data wrong");
  chk_read_route: assert property (
    arr_read_addr == s_axi_araddr[ARR_AW-1:0])
    else $error("read address not routed");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // bits only move with a write answer, so stray updates show up here
  chk_power_edge: assert property ($rose(program_power_on)
    |-> $rose(s_axi_bvalid)) else $error("power rose without write");
  chk_mode_write: assert property ($changed(array_latch_mode)
    |-> $rose(s_axi_bvalid)) else $error("mode moved without write");
  chk_prog_target: assert property ($changed(arr_prog_addr)
    |-> $rose(s_axi_bvalid)) else $error("target moved without write");
endmodule

// ---- sim/test_eprom_program_control.sv ----
// bench for the eprom program-control block
// assumes the bus answers in a few cycles; array data driven here
`timescale 1ns/100ps
`include "epc_params.svh"
module test_eprom_program_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic array_latch_mode, program_power_on, t;
  logic [11:0] s_axi_awaddr, s_axi_araddr, arr_read_addr, arr_prog_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] arr_read_data, arr_prog_data;
  int failures, samples_checked;
  epc_top uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .arr_read_addr(arr_read_addr),
    .arr_read_data(arr_read_data),
    .arr_prog_addr(arr_prog_addr),
    .arr_prog_data(arr_prog_data),
    .array_latch_mode(array_latch_mode),
    .program_power_on(program_power_on)
  );
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // ready sampled half a cycle early; inputs only move at rising edges
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do begin
      @(negedge aclk);
      t = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (!t);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] bits();
    return {30'h0, array_latch_mode, program_power_on};
  endfunction
  task automatic t_gate();
    rdr(`EPC_CTRL_BYTE_ADDR);
    check("ctrl reset", rd, 32'h0000_0000);
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0001);
    check("pgm alone", bits(), 32'h0000_0000);
    wr(`EPC_CTRL_BYTE_ADDR, 32'hFFFF_FFFF);
    rdr(`EPC_CTRL_BYTE_ADDR);
    check("ctrl ones", rd, 32'h0000_0003);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("bits reset", bits(), 32'h0000_0000);
    rdr(`EPC_CTRL_BYTE_ADDR);
    check("ctrl after reset", rd, {24'h00_0000, `EPC_CTRL_RESET});
    $display("test gate done");
  endtask
  task automatic t_program();
    arr_read_data <= 8'h5A;
    // programming voltage taken as present from here on
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0002);
    rdr(`EPC_ARRAY_ADDR);
    check("locked read", rd, 32'h0000_0000);
    wr(`EPC_ARRAY_ADDR, 32'h0000_00A5);
    check("paddr pin", {20'h0_0000, arr_prog_addr}, 32'h0000_0080);
    check("pdata pin", {24'h00_0000, arr_prog_data}, 32'h0000_00A5);
    rdr(`EPC_PROG_ADDR_ADDR);
    check("prog addr", rd, 32'h0000_0080);
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0003);
    check("power on", bits(), 32'h0000_0003);
    // full pulse; its length is software's, not the block's
    repeat (`EPC_PULSE_TIME_US * `EPC_CLK_MHZ) @(posedge aclk);
    check("power held", bits(), 32'h0000_0003);
    // power and latch dropped by two separate writes
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0002);
    check("power off", bits(), 32'h0000_0002);
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0000);
    rdr(`EPC_ARRAY_ADDR);
    check("plain read", rd, 32'h0000_005A);
    wr(`EPC_ARRAY_ADDR, 32'h0000_0011);
    check("pdata kept", {24'h00_0000, arr_prog_data}, 32'h0000_00A5);
    rdr(`EPC_PROG_DATA_ADDR);
    check("prog data", rd, 32'h0000_00A5);
    $display("test program done");
  endtask
  task automatic t_refuse();
    wr(12'h040, 32'h0000_0002);
    check("wr unmapped", {30'h0, rs}, 32'h0000_0002);
    rdr(12'h040);
    check("rd unmapped", {30'h0, rs}, 32'h0000_0002);
    s_axi_wstrb <= 4'h0;
    wr(`EPC_CTRL_BYTE_ADDR, 32'h0000_0002);
    s_axi_wstrb <= 4'hF;
    check("no strobe", bits(), 32'h0000_0000);
    $display("test refuse done");
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    // about one and a half runs, programming pulse included
    #1500000;
    failures++;
    final_report();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    arr_read_data = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_gate();
    t_program();
    t_refuse();
    final_report();
  end
endmodule
bind epc_top epc_assertions #(.ADDR_W(ADDR_W), .ARR_AW(ARR_AW)) chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid),
  .arr_read_addr(arr_read_addr),
  .arr_read_data(arr_read_data),
  .arr_prog_addr(arr_prog_addr),
  .array_latch_mode(array_latch_mode),
  .program_power_on(program_power_on)
);
